// [logic/ibox_irq_pkg.sv]
// Purpose: Shared constants and types for the instruction-unit interrupt registers
// Assumes: Privileged register moves carry an 8-bit register index and 64-bit data
// Notes: Indices other than the enable/mode group are placement values

package ibox_irq_pkg;

    // ****************************************
    // Register indices
    // ****************************************
    localparam logic [7:0] IDX_FETCH_FAULT_FORMAT = 8'h05;
    localparam logic [7:0] IDX_TRAP_SUMMARY = 8'h06;
    localparam logic [5:0] IDX_IRQ_ENABLE_AND_MODE_BASE = 6'h02;
    localparam logic [7:0] IDX_SOFTWARE_REQUEST = 8'h0C;
    localparam logic [7:0] IDX_PENDING_SUMMARY = 8'h0D;
    localparam logic [7:0] IDX_INTERRUPT_CLEAR = 8'h0E;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int EN_HI = 38;
    localparam int EN_LO = 13;
    localparam int EXT_HI = 38;
    localparam int EXT_LO = 33;
    localparam int SL_BIT = 32;
    localparam int CR_BIT = 31;
    localparam int PC_HI = 30;
    localparam int PC_LO = 29;
    localparam int SI_HI = 28;
    localparam int SI_LO = 14;
    localparam int ASYNC_TRAP_ENABLE_BIT = 13;
    localparam int CM_HI = 4;
    localparam int CM_LO = 3;
    localparam int MCHK_BIT = 28;
    localparam int FORCE_BAD_FILL_PARITY_BIT = 26;
    localparam int AST_USER_BIT = 10;
    localparam int AST_SUPER_BIT = 9;
    localparam int AST_EXEC_BIT = 4;
    localparam int AST_KERNEL_BIT = 3;
    localparam int TS_FLAG_HI = 47;
    localparam int TS_FLAG_LO = 42;
    localparam int TS_FETCH_ADDRESS_OVERFLOW_BIT = 41;
    localparam int TS_FETCH_ADDRESS_LOCATION_BIT = 13;
    localparam int TS_REG_HI = 12;
    localparam int TS_REG_LO = 8;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [25:0] IER_RESET = 26'h0000000;
    localparam logic [1:0] CM_RESET = 2'h0;
    localparam logic [63:0] ZERO64 = 64'h0000000000000000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_KERNEL = 2'b00,
        MODE_EXECUTIVE = 2'b01,
        MODE_SUPERVISOR = 2'b10,
        MODE_USER = 2'b11
    } mode_t;

    typedef struct packed {
        logic serial;
        logic corrected;
        logic [1:0] perf;
        logic mcheck;
    } hw_events_t;

    typedef struct packed {
        logic [5:0] fp_flags;
        logic pc_overflow;
        logic fetch_address_location;
        logic is_store;
        logic [4:0] src_reg;
        logic [4:0] dst_reg;
    } trap_info_t;

endpackage

// [logic/ibox_interrupt_exception_regs.sv]
// Purpose: Interrupt enable/mode, pending summary, clear and trap summary registers
// Assumes: One core clock; privileged moves arrive as one-cycle strobes
// Notes: Read data appears one cycle after the read strobe

`timescale 1ns/10ps
`default_nettype none

module ibox_interrupt_exception_regs
    import ibox_irq_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic priv_write_valid,
    input wire logic [7:0] priv_write_index,
    input wire logic [63:0] priv_write_data,
    input wire logic priv_read_valid,
    input wire logic [7:0] priv_read_index,
    output logic [63:0] priv_read_data_q,
    output logic priv_read_valid_q,
    input wire logic [63:0] exception_address,
    input wire logic [47:30] page_table_base,
    input wire logic wide_address_select,
    input wire logic short_format_select,
    input wire logic [5:0] external_irq_pins,
    input wire hw_events_t hw_events,
    input wire logic [3:0] async_trap_enable_bits,
    input wire logic [3:0] async_trap_request_bits,
    input wire logic trap_deliver,
    input wire trap_info_t trap_info,
    input wire logic icache_fill_bcache_hit,
    output logic force_bad_fill_parity_q,
    output logic [1:0] current_mode_q,
    output logic irq_request_q,
    output logic data_machine_check_q
);

    // ****************************************
    // Fetch fault formatting
    // ****************************************
    function automatic logic [63:0] fetch_form(
        input logic [63:0] va,
        input logic [47:30] ptb,
        input logic wide,
        input logic short_fmt
    );
        logic [63:0] base;
        logic [63:0] res;
        begin
            base = {{16{ptb[47]}}, ptb, 30'h00000000};
            if (short_fmt) begin
                res = {base[63:22], va[31:13], 3'h0};
            end else if (wide) begin
                res = {base[63:38], va[47:13], 3'h0};
            end else begin
                res = {base[63:33], va[42:13], 3'h0};
            end
            fetch_form = res;
        end
    endfunction

    // Enable/mode group decode, shared by reads and writes
    function automatic logic irq_enable_and_mode_hit(input logic [7:0] idx);
        return idx[7:2] == IDX_IRQ_ENABLE_AND_MODE_BASE;
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [5:0] ext_meta_q;
    logic [5:0] ext_sync_q;
    logic [5:0] ext_prev_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            ext_meta_q <= 6'h00;
            ext_sync_q <= 6'h00;
            ext_prev_q <= 6'h00;
        end else begin
            ext_meta_q <= external_irq_pins;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    // ****************************************
    // State
    // ****************************************
    logic [25:0] ier_q;
    logic [25:0] ier_d;
    logic [1:0] cm_d;
    logic [14:0] software_request_reg_q;
    logic [14:0] software_request_reg_d;
    logic sl_q;
    logic sl_d;
    logic cr_q;
    logic cr_d;
    logic [1:0] pc_q;
    logic [1:0] pc_d;
    logic data_machine_check_clear;
    logic force_bad_fill_parity_d;
    logic [63:0] trap_sum_q;
    logic [63:0] trap_sum_d;

    // ****************************************
    // Write decode
    // ****************************************
    wire irq_enable_and_mode_sel = priv_write_valid && irq_enable_and_mode_hit(priv_write_index);
    wire wr_ier = irq_enable_and_mode_sel && priv_write_index[1];
    wire wr_cm = irq_enable_and_mode_sel && priv_write_index[0];
    wire wr_software_request_reg = priv_write_valid && (priv_write_index == IDX_SOFTWARE_REQUEST);
    wire wr_clr = priv_write_valid && (priv_write_index == IDX_INTERRUPT_CLEAR);

    wire clr_sl = wr_clr && priv_write_data[SL_BIT];
    wire clr_cr = wr_clr && priv_write_data[CR_BIT];
    wire [1:0] clr_pc = wr_clr ? priv_write_data[PC_HI:PC_LO] : 2'h0;
    wire clr_mchk = wr_clr && priv_write_data[MCHK_BIT];
    wire set_force_bad_fill_parity = wr_clr && priv_write_data[FORCE_BAD_FILL_PARITY_BIT];

    // ****************************************
    // Next state
    // ****************************************
    assign ier_d = wr_ier ? priv_write_data[EN_HI:EN_LO] : ier_q;
    assign cm_d = wr_cm ? priv_write_data[CM_HI:CM_LO] : current_mode_q;
    assign software_request_reg_d = wr_software_request_reg ? priv_write_data[SI_HI:SI_LO] : software_request_reg_q;

    // Set wins over a clear in the same cycle
    assign sl_d = (sl_q && !clr_sl) || hw_events.serial;
    assign cr_d = (cr_q && !clr_cr) || hw_events.corrected;
    assign pc_d = (pc_q & ~clr_pc) | hw_events.perf;
    assign data_machine_check_clear = (data_machine_check_q && !clr_mchk) || hw_events.mcheck;

    // Armed until the next board-cache fill consumes it
    assign force_bad_fill_parity_d = set_force_bad_fill_parity
        || (force_bad_fill_parity_q && !icache_fill_bcache_hit);

    // ****************************************
    // Trap capture
    // ****************************************
    wire [4:0] trap_reg = trap_info.is_store ? trap_info.src_reg
                                             : trap_info.dst_reg;

    logic [63:0] trap_capture;
    always_comb begin
        trap_capture = ZERO64;
        trap_capture[TS_FLAG_HI:TS_FLAG_LO] = trap_info.fp_flags;
        trap_capture[63:48] = {16{trap_info.fp_flags[5]}};
        trap_capture[TS_FETCH_ADDRESS_OVERFLOW_BIT] = trap_info.pc_overflow;
        trap_capture[TS_FETCH_ADDRESS_LOCATION_BIT] = trap_info.fetch_address_location;
        trap_capture[TS_REG_HI:TS_REG_LO] = trap_reg;
    end

    assign trap_sum_d = trap_deliver ? trap_capture : trap_sum_q;

    // ****************************************
    // Pending summary
    // ****************************************
    wire [5:0] ext_en = ier_q[EXT_HI-EN_LO:EXT_LO-EN_LO];
    wire sl_en = ier_q[SL_BIT-EN_LO];
    wire cr_en = ier_q[CR_BIT-EN_LO];
    wire [1:0] pc_en = ier_q[PC_HI-EN_LO:PC_LO-EN_LO];
    wire [14:0] si_en = ier_q[SI_HI-EN_LO:SI_LO-EN_LO];
    wire ast_en = ier_q[ASYNC_TRAP_ENABLE_BIT-EN_LO];

    // Index 0 kernel .. 3 user; mode value at least that mode
    logic [3:0] ast_pend;
    always_comb begin
        for (int m = 0; m < 4; m++) begin
            ast_pend[m] = ast_en && async_trap_enable_bits[m]
                && async_trap_request_bits[m]
                && (current_mode_q >= 2'(m));
        end
    end

    logic [63:0] summary;
    always_comb begin
        summary = ZERO64;
        summary[EXT_HI:EXT_LO] = ext_sync_q & ext_en;
        summary[SL_BIT] = sl_q && sl_en;
        summary[CR_BIT] = cr_q && cr_en;
        summary[PC_HI:PC_LO] = pc_q & pc_en;
        summary[SI_HI:SI_LO] = software_request_reg_q & si_en;
        summary[AST_USER_BIT] = ast_pend[MODE_USER];
        summary[AST_SUPER_BIT] = ast_pend[MODE_SUPERVISOR];
        summary[AST_EXEC_BIT] = ast_pend[MODE_EXECUTIVE];
        summary[AST_KERNEL_BIT] = ast_pend[MODE_KERNEL];
    end

    // A fresh hardware request racing a summary read
    wire new_hw_irq = (|(ext_sync_q & ~ext_prev_q)) || hw_events.serial
        || hw_events.corrected || (|hw_events.perf);

    // ****************************************
    // Read mux
    // ****************************************
    wire [63:0] irq_enable_and_mode_word = {25'h0000000, ier_q, 8'h00, current_mode_q, 3'h0};
    wire [63:0] form_word = fetch_form(exception_address, page_table_base,
        wide_address_select, short_format_select);
    wire [63:0] software_request_reg_word = {35'h000000000, software_request_reg_q, 14'h0000};
    wire rd_irq_enable_and_mode = irq_enable_and_mode_hit(priv_read_index);

    logic [63:0] read_mux;
    always_comb begin
        read_mux = ZERO64;
        if (rd_irq_enable_and_mode) begin
            read_mux = irq_enable_and_mode_word;
        end else begin
            case (priv_read_index)
                IDX_FETCH_FAULT_FORMAT: read_mux = form_word;
                IDX_SOFTWARE_REQUEST: read_mux = software_request_reg_word;
                IDX_PENDING_SUMMARY: read_mux = new_hw_irq ? ZERO64 : summary;
                IDX_TRAP_SUMMARY: read_mux = trap_sum_q;
                default: read_mux = ZERO64;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            ier_q <= IER_RESET;
            current_mode_q <= CM_RESET;
        end else begin
            ier_q <= ier_d;
            current_mode_q <= cm_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            software_request_reg_q <= 15'h0000;
            sl_q <= 1'b0;
            cr_q <= 1'b0;
            pc_q <= 2'h0;
        end else begin
            software_request_reg_q <= software_request_reg_d;
            sl_q <= sl_d;
            cr_q <= cr_d;
            pc_q <= pc_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            data_machine_check_q <= 1'b0;
            force_bad_fill_parity_q <= 1'b0;
        end else begin
            data_machine_check_q <= data_machine_check_clear;
            force_bad_fill_parity_q <= force_bad_fill_parity_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trap_sum_q <= ZERO64;
        end else begin
            trap_sum_q <= trap_sum_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            priv_read_data_q <= ZERO64;
            priv_read_valid_q <= 1'b0;
            irq_request_q <= 1'b0;
        end else begin
            priv_read_data_q <= priv_read_valid ? read_mux : ZERO64;
            priv_read_valid_q <= priv_read_valid;
            irq_request_q <= |summary;
        end
    end

endmodule

`default_nettype wire

// [tb/ibox_irq_monitor.sv]
// Purpose: Port checks for the interrupt and trap register block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to the block below its endmodule
`timescale 1ns/10ps
`default_nettype none
module ibox_irq_monitor
    import ibox_irq_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic priv_write_valid,
    input wire logic [7:0] priv_write_index,
    input wire logic [63:0] priv_write_data,
    input wire logic priv_read_valid,
    input wire logic [7:0] priv_read_index,
    input wire logic [63:0] priv_read_data_q,
    input wire logic priv_read_valid_q,
    input wire hw_events_t hw_events,
    input wire logic icache_fill_bcache_hit,
    input wire logic force_bad_fill_parity_q,
    input wire logic [1:0] current_mode_q,
    input wire logic data_machine_check_q
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire ier_wr = priv_write_valid && (priv_write_index[7:2] == IDX_IRQ_ENABLE_AND_MODE_BASE);
    wire clr_wr = priv_write_valid && (priv_write_index == IDX_INTERRUPT_CLEAR);
    wire new_hw = hw_events.serial || hw_events.corrected || (|hw_events.perf);
    property p_rd_lat; priv_read_valid |=> priv_read_valid_q; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_mode_wr;
        ier_wr && priv_write_index[0]
            |=> current_mode_q == $past(priv_write_data[CM_HI:CM_LO]);
    endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("mode not written");
    property p_mode_keep;
        !(ier_wr && priv_write_index[0]) |=> $stable(current_mode_q);
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("mode changed");
    property p_fbp_set;
        clr_wr && priv_write_data[FORCE_BAD_FILL_PARITY_BIT] |=> force_bad_fill_parity_q;
    endproperty
    a_fbp_set: assert property (p_fbp_set) else $error("parity not armed");
    property p_fbp_use;
        force_bad_fill_parity_q && icache_fill_bcache_hit && !clr_wr
            |=> !force_bad_fill_parity_q;
    endproperty
    a_fbp_use: assert property (p_fbp_use) else $error("parity not consumed");
    property p_mchk_set; hw_events.mcheck |=> data_machine_check_q [*2]; endproperty
    a_mchk_set: assert property (p_mchk_set) else $error("check not held");
    property p_mchk_clr;
        clr_wr && priv_write_data[MCHK_BIT] && !hw_events.mcheck
            |=> !data_machine_check_q;
    endproperty
    a_mchk_clr: assert property (p_mchk_clr) else $error("check not cleared");
    property p_collide;
        priv_read_valid && priv_read_index == IDX_PENDING_SUMMARY && new_hw
            |=> priv_read_data_q == ZERO64;
    endproperty
    a_collide: assert property (p_collide) else $error("collided read not zero");
endmodule
bind ibox_interrupt_exception_regs ibox_irq_monitor i_mon (.clk(clk), .reset(reset),
    .priv_write_valid(priv_write_valid), .priv_write_index(priv_write_index),
    .priv_write_data(priv_write_data), .priv_read_valid(priv_read_valid),
    .priv_read_index(priv_read_index), .priv_read_data_q(priv_read_data_q),
    .priv_read_valid_q(priv_read_valid_q), .hw_events(hw_events),
    .icache_fill_bcache_hit(icache_fill_bcache_hit),
    .force_bad_fill_parity_q(force_bad_fill_parity_q), .current_mode_q(current_mode_q),
    .data_machine_check_q(data_machine_check_q));
`default_nettype wire

// [tb/ibox_core_model.sv]
// Purpose: Pipeline model issuing privileged register moves
// Assumes: Requests launched and released on falling edges
// Notes: Released index and data lines show inverted values
`timescale 1ns/10ps
`default_nettype none
module ibox_core_model (
    input wire logic clk,
    output logic w_v = 1'b0,
    output logic [7:0] w_i = 8'h00,
    output logic [63:0] w_d = 64'h0,
    output logic r_v = 1'b0,
    output logic [7:0] r_i = 8'h00,
    input wire logic [63:0] r_d,
    input wire logic r_q
);
    // ****************************************
    // Moves
    // ****************************************
    task automatic wr(input logic [7:0] idx, input logic [63:0] d);
        @(negedge clk);
        {w_v, w_i, w_d} = {1'b1, idx, d};
        @(negedge clk);
        {w_v, w_i, w_d} = {1'b0, ~idx, ~d};
    endtask
    task automatic rd(input logic [7:0] idx, output logic [63:0] d);
        @(negedge clk);
        {r_v, r_i} = {1'b1, idx};
        @(negedge clk);
        {r_v, r_i} = {1'b0, ~idx};
        d = r_q ? r_d : 64'hX;
    endtask
    task automatic rd2(input logic [7:0] idx, output logic [63:0] d);
        logic [63:0] a;
        rd(idx, a);
        rd(idx, d);
        d = d | a;
    endtask
endmodule
`default_nettype wire

// [tb/test_ibox_interrupt_exception_regs.sv]
// Purpose: Register-level tests of the interrupt and trap block
// Assumes: Inputs change on falling edges
// Notes: External pins driven by the bench
`timescale 1ns/10ps
`default_nettype none
module test_ibox_interrupt_exception_regs
    import ibox_irq_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wide = 1'b0, short_f = 1'b0, tdel = 1'b0, fill = 1'b0;
    logic [63:0] exc = 64'h0, v;
    logic [47:30] ptb = 18'h0;
    logic [3:0] aen = 4'h0, areq = 4'h0;
    logic [5:0] pins = 6'h00;
    hw_events_t ev = '0;
    trap_info_t ti = '0;
    wire logic w_v, r_v, r_q, fbp, irq, mchk;
    wire logic [7:0] w_i, r_i;
    wire logic [63:0] w_d, r_d;
    wire logic [1:0] mode;
    int mismatches = 0, compares = 0, cycles = 0;
    localparam logic [63:0] AST [4] = '{64'h8, 64'h18, 64'h218, 64'h618};
    // ****************************************
    // Harness
    // ****************************************
    always #2.5 clk = ~clk;
    ibox_core_model i_core (.clk(clk), .w_v(w_v), .w_i(w_i), .w_d(w_d), .r_v(r_v),
        .r_i(r_i), .r_d(r_d), .r_q(r_q));
    ibox_interrupt_exception_regs i_dut (.clk(clk), .reset(reset), .priv_write_valid(w_v),
        .priv_write_index(w_i), .priv_write_data(w_d), .priv_read_valid(r_v),
        .priv_read_index(r_i), .priv_read_data_q(r_d), .priv_read_valid_q(r_q),
        .exception_address(exc), .page_table_base(ptb), .wide_address_select(wide),
        .short_format_select(short_f), .external_irq_pins(pins), .hw_events(ev),
        .async_trap_enable_bits(aen), .async_trap_request_bits(areq), .trap_deliver(tdel),
        .trap_info(ti), .icache_fill_bcache_hit(fill), .force_bad_fill_parity_q(fbp),
        .current_mode_q(mode), .irq_request_q(irq), .data_machine_check_q(mchk));
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] idx, input logic [63:0] e, input string n);
        i_core.rd(idx, v);
        chk(n, e, v);
    endtask
    task automatic pulse(input hw_events_t e);
        @(negedge clk);
        ev = e;
        @(negedge clk);
        ev = '0;
    endtask
    task automatic trap(input trap_info_t t);
        ti = t;
        @(negedge clk);
        tdel = 1'b1;
        @(negedge clk);
        tdel = 1'b0;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        rc(8'h08, ZERO64, "ier reset");
        i_core.wr(8'h0B, 64'hFFFFFFFFFFFFFFFF);
        rc(8'h0A, 64'h7FFFFFE018, "ier both");
        i_core.wr(8'h09, 64'h8);
        rc(8'h09, 64'h7FFFFFE008, "mode only");
        i_core.wr(8'h0A, ZERO64);
        i_core.wr(8'h08, 64'hFFFFFFFFFFFFFFFF);
        i_core.wr(8'h07, 64'hFFFFFFFFFFFFFFFF);
        rc(8'h0B, 64'h8, "enables only");
        rc(8'hFF, ZERO64, "unmapped");
        for (int m = 0; m < 4; m++) begin
            i_core.wr(8'h09, 64'(m) << CM_LO);
            chk("mode", 64'(m), {62'h0, mode});
        end
        $display("test registers done");
        i_core.wr(8'h0C, 64'h4000);
        rc(8'h0C, 64'h4000, "sw request");
        rc(8'h0D, ZERO64, "sw masked");
        i_core.wr(8'h0A, 64'h1FFFC000);
        i_core.rd2(8'h0D, v);
        chk("sw pending", 64'h4000, v);
        chk("irq on", 64'h1, {63'h0, irq});
        i_core.wr(8'h0C, ZERO64);
        repeat (2) @(negedge clk);
        chk("irq off", ZERO64, {63'h0, irq});
        {aen, areq} = 8'hFF;
        i_core.wr(8'h0A, 64'h2000);
        for (int m = 0; m < 4; m++) begin
            i_core.wr(8'h09, 64'(m) << CM_LO);
            rc(8'h0D, AST[m], "async trap");
        end
        aen = 4'h0;
        rc(8'h0D, ZERO64, "trap unarmed");
        $display("test summary done");
        i_core.wr(8'h0A, 64'h1E0000000);
        pulse(5'b10000);
        rc(8'h0D, 64'h100000000, "serial");
        i_core.wr(8'h0E, 64'h100000000);
        rc(8'h0D, ZERO64, "serial clr");
        fork
            rc(8'h0D, ZERO64, "collide");
            pulse(5'b01000);
        join
        rc(8'h0D, 64'h80000000, "resignal");
        pulse(5'b00111);
        rc(8'h0D, 64'hE0000000, "perf");
        chk("mchk", 64'h1, {63'h0, mchk});
        i_core.wr(8'h0E, 64'h1F0000000);
        chk("mchk clr", ZERO64, {63'h0, mchk});
        rc(8'h0D, ZERO64, "all clr");
        i_core.wr(8'h0E, 64'h4000000);
        chk("parity armed", 64'h1, {63'h0, fbp});
        rc(8'h0E, ZERO64, "clear reads");
        fill = 1'b1;
        @(negedge clk);
        fill = 1'b0;
        chk("parity used", ZERO64, {63'h0, fbp});
        i_core.wr(8'h0A, 64'h7E00000000);
        pins = 6'h21;
        repeat (3) @(negedge clk);
        rc(8'h0D, 64'h4200000000, "external");
        pins = 6'h23;
        @(negedge clk);
        rc(8'h0D, ZERO64, "ext collide");
        rc(8'h0D, 64'h4600000000, "ext resignal");
        pins = 6'h00;
        $display("test events done");
        trap('{6'b100001, 1'b1, 1'b1, 1'b1, 5'h15, 5'h0A});
        rc(8'h06, 64'hFFFF860000003500, "trap store");
        i_core.wr(8'h06, ZERO64);
        rc(8'h06, 64'hFFFF860000003500, "trap ro");
        trap('{6'b010000, 1'b0, 1'b0, 1'b0, 5'h15, 5'h0A});
        rc(8'h06, 64'h400000000A00, "trap load");
        {exc, ptb} = {64'hFFFFFFFFFFFFFFFF, 18'h20000};
        rc(8'h05, 64'hFFFF8001FFFFFFF8, "format 43");
        wide = 1'b1;
        rc(8'h05, 64'hFFFF803FFFFFFFF8, "format 48");
        {wide, short_f} = 2'b11;
        rc(8'h05, 64'hFFFF8000003FFFF8, "format 32");
        $display("test trap done");
        end_sim();
    end
endmodule
`default_nettype wire
